// ===== design/lcd_ctrl_regs.vh
// Purpose: constants for the lcd driver control block
// Assumes: 32-bit apb, byte addresses, 100 MHz pclk
// Notes:
// Contract
// - display reset is not-enable OR sleep OR mcu reset float hold.
// - enable cleared, no sleep, no mcu reset: reset display, drive lines low.
// - sleep resets display and drives lines low even with enable set.
// - mcu reset resets display and floats all lines for its whole duration.
// - mcu reset display hold lasts reset delay plus startup settle time.
// - watchdog reset during idle or sleep is not an mcu reset.
// - four common lines at fixed 1/4 duty, four divisions per frame.
// - waveform type a or b by control bit; type b lower frequency.
// - bias kind bit picks resistor or pump; pump runs only in pump kind.
// - in pump kind a two-bit field picks the bias source.
// - pump boosts only when source is external supply pin.
// - enable zero stops all drive waveforms.
// - enable is zero after power-on.
// - source 00 external, 01 reference, 10 core to middle, 11 core to top.
// - bias kind 0 resistor, 1 charge pump.
`ifndef LCD_CTRL_REGS_VH
`define LCD_CTRL_REGS_VH
`define CTRL_OFS        12'h000
`define STATUS_OFS      12'h004
`define CTRL_RESET      32'h0000_0000
`define EN_BIT          0
`define SRC_LSB         4
`define SRC_MSB         5
`define BIAS_BIT        6
`define TYPE_BIT        7
`define SRC_EXT         2'b00
`define SRC_REF         2'b01
`define SRC_CORE_MID    2'b10
`define SRC_CORE_TOP    2'b11
`define RSTD_NS         1000
`define SST_NS          1000
`define PCLK_NS         10
`define HOLD_CYCLES     ((`RSTD_NS + `SST_NS + `PCLK_NS - 1) / `PCLK_NS)
`define DIV_A           16
`endif

// ===== design/lcd_phase_gen.v
// Purpose: common phase and half-period generator
// Assumes: clear held while display reset
// Notes: type b doubles the divider so its drive frequency is half
`timescale 1ns/1ns
module lcd_phase_gen #(
  parameter DIV = 16
) (
  input  wire       clk,        // clock
  input  wire       rst_n,      // async reset
  input  wire       clear,      // synchronous hold
  input  wire       type_b,     // waveform type b
  output reg  [1:0] phase,      // active common
  output reg        polarity    // ac inversion
);
  localparam [15:0] DIV_W = DIV;
  reg [15:0] cnt_q;
  wire [15:0] limit = type_b ? {DIV_W[14:0], 1'b0} - 16'd1 : DIV_W - 16'd1;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q    <= 16'h0000;
      phase    <= 2'h0;
      polarity <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q    <= 16'h0000;
      phase    <= 2'h0;
      polarity <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q <= 16'h0000;
      phase <= phase + 2'h1;
      if (phase == 2'h3 || type_b)
        polarity <= ~polarity;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule

// ===== design/lcd_driver_control.v
// Purpose: lcd driver control, reset and output state
// Assumes: mcu_reset, sleep and wdt inputs are asynchronous pins
// Notes: segment data comes from display memory outside this block
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "lcd_ctrl_regs.vh"
module lcd_driver_control #(
  parameter NSEG        = 8,
  parameter HOLD_CYCLES = `HOLD_CYCLES,
  parameter DIV         = `DIV_A
) (
  input  wire            pclk,          // clock
  input  wire            presetn,       // async reset, active low
  input  wire            psel,          // apb select
  input  wire            penable,       // apb enable
  input  wire            pwrite,        // apb direction
  input  wire [11:0]     paddr,         // apb address
  input  wire [31:0]     pwdata,        // apb write data
  output reg  [31:0]     prdata,        // apb read data
  output reg             pready,        // apb ready
  output reg             pslverr,       // apb error
  input  wire            mcu_reset,     // mcu reset request, high
  input  wire            wdt_reset,     // reset source is watchdog time-out
  input  wire            idle_mode,     // device in idle
  input  wire            sleep_mode,    // device in sleep
  input  wire [4*NSEG-1:0] seg_data,    // pixel bits, 4 per segment line
  output reg  [3:0]      com_level,     // common drive level
  output reg  [3:0]      com_oe_n,      // common enable, low drives
  output reg  [NSEG-1:0] segment_line,  // segment drive level
  output reg  [NSEG-1:0] seg_oe_n,      // segment enable, low drives
  output reg             pump_enable,   // charge pump run
  output reg             pump_boost,    // pump raises above supply
  output reg  [1:0]      pump_source,   // decoded source select
  output reg             display_reset  // internal display reset
);
  localparam [15:0] HOLD_W = HOLD_CYCLES;
  reg [31:0] ctrl_q;
  reg [2:0]  rst_s, slp_s, wdt_s, idl_s;
  reg        mrst_q, slp_q;
  reg [15:0] hold_q;
  wire       display_enable      = ctrl_q[`EN_BIT];
  wire [1:0] pump_source_select  = ctrl_q[`SRC_MSB:`SRC_LSB];
  wire       bias_kind_select    = ctrl_q[`BIAS_BIT];
  wire       wave_type_b         = ctrl_q[`TYPE_BIT];
  wire [1:0] phase;
  wire       polarity;
  // three stages; a reset or sleep level counts once stages two and three agree, watchdog and idle use stage three
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_s  <= 3'h0;
      slp_s  <= 3'h0;
      wdt_s  <= 3'h0;
      idl_s  <= 3'h0;
      mrst_q <= 1'b0;
      slp_q  <= 1'b0;
    end
    else
    begin
      rst_s <= {rst_s[1:0], mcu_reset};
      slp_s <= {slp_s[1:0], sleep_mode};
      wdt_s <= {wdt_s[1:0], wdt_reset};
      idl_s <= {idl_s[1:0], idle_mode};
      if (rst_s[2] == rst_s[1])
        mrst_q <= rst_s[2] & ~(wdt_s[2] & (idl_s[2] | slp_s[2]));
      if (slp_s[2] == slp_s[1])
        slp_q <= slp_s[2];
    end
  end
  // the float hold outlives the pin so the panel sees the full delay plus settle
  wire floating = mrst_q | (hold_q != 16'h0000);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= 16'h0000;
    else if (mrst_q)
      hold_q <= HOLD_W;
    else if (hold_q != 16'h0000)
      hold_q <= hold_q - 16'h0001;
  end
  wire rst_d = ~display_enable | slp_q | floating;
  // apb slave, zero wait states
  wire setup = psel & ~penable;
  // a write lands only at the access edge where ready is seen high
  wire access = psel & penable & pready;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= `CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & (paddr != `CTRL_OFS) & (paddr != `STATUS_OFS);
      if (access & pwrite & (paddr == `CTRL_OFS))
        ctrl_q <= {24'h000000, pwdata[7:4], 3'h0, pwdata[0]};
      if (setup & ~pwrite)
      begin
        if (paddr == `CTRL_OFS)
          prdata <= ctrl_q;
        else if (paddr == `STATUS_OFS)
          prdata <= {26'h0, pump_boost, pump_enable, floating, slp_q, mrst_q, rst_d};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end
  lcd_phase_gen #(
    .DIV      (DIV)
  ) u_phase (
    .clk      (pclk),
    .rst_n    (presetn),
    .clear    (rst_d),
    .type_b   (wave_type_b),
    .phase    (phase),
    .polarity (polarity)
  );
  function pix_on;
    input [4*NSEG-1:0] d;
    input integer      s;
    input [1:0]        p;
    begin
      pix_on = d[4*s + p];
    end
  endfunction
  // level encoding is digital: 1 = select level at polarity 0, all bits inverted at polarity 1
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      com_level     <= 4'h0;
      com_oe_n      <= 4'hF;
      display_reset <= 1'b1;
      pump_enable   <= 1'b0;
      pump_boost    <= 1'b0;
      pump_source   <= `SRC_EXT;
    end
    else
    begin
      display_reset <= rst_d;
      pump_enable   <= bias_kind_select & ~rst_d;
      pump_source   <= bias_kind_select ? pump_source_select : `SRC_EXT;
      pump_boost    <= bias_kind_select & ~rst_d &
                       (pump_source_select == `SRC_EXT);
      com_oe_n      <= floating ? 4'hF : 4'h0;
      if (rst_d)
        com_level <= 4'h0;
      else
        com_level <= (4'h1 << phase) ^ {4{polarity}};
    end
  end
  genvar g;
  generate
    for (g = 0; g < NSEG; g = g + 1)
    begin : seg_drv
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          segment_line[g] <= 1'b0;
          seg_oe_n[g]     <= 1'b1;
        end
        else
        begin
          seg_oe_n[g] <= floating;
          if (rst_d)
            segment_line[g] <= 1'b0;
          else
            segment_line[g] <= pix_on(seg_data, g, phase) ^ polarity;
        end
      end
    end
  endgenerate
endmodule

// ===== testbench/lcd_driver_control_asserts.sv
// Purpose: port checks of the lcd driver control
// Assumes: HOLD_CYCLES 5 and DIV 2
// Notes: pin filters lag about 4 cycles, so waits use 6
`timescale 1ns/1ns
module lcd_ctrl_checker (
  input wire logic       pclk,          // clock
  input wire logic       presetn,       // reset
  input wire logic       psel,          // select
  input wire logic       penable,       // enable
  input wire logic       pready,        // ready
  input wire logic       mcu_reset,     // mcu reset
  input wire logic       wdt_reset,     // watchdog cause
  input wire logic       sleep_mode,    // sleep
  input wire logic [3:0] com_level,     // commons
  input wire logic [3:0] com_oe_n,      // common enables
  input wire logic       pump_enable,   // pump run
  input wire logic       pump_boost,    // pump boost
  input wire logic [1:0] pump_source,   // pump source
  input wire logic       display_reset  // display reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pump_off_a: assert property (display_reset [*2] |-> !pump_enable && !pump_boost)
    else $error("pump runs in reset");
  boost_src_a: assert property (pump_boost |-> pump_enable && pump_source == 2'h0)
    else $error("boost from wrong source");
  low_rst_a: assert property (display_reset [*2] |-> com_level == 4'h0)
    else $error("commons not low");
  sleep_rst_a: assert property (sleep_mode [*6] |-> display_reset)
    else $error("sleep without reset");
  float_a: assert property ((mcu_reset && !wdt_reset) [*6] |-> com_oe_n == 4'hF)
    else $error("commons driven in reset");
  hold_a: assert property ($fell(mcu_reset) && com_oe_n == 4'hF |=>
    (com_oe_n == 4'hF) [*4] ##[1:20] (com_oe_n == 4'h0)) else $error("hold length wrong");
  duty_a: assert property (!display_reset [*3] |-> $onehot(com_level) || $onehot(~com_level))
    else $error("not one common");
  ready_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  cover property (pump_boost);
  cover property ($rose(com_oe_n[0]));
  cover property (sleep_mode && display_reset);
endmodule
bind lcd_driver_control lcd_ctrl_checker lcd_ctrl_checker_inst (.*);

// ===== testbench/lcd_panel_model.sv
// Purpose: panel seen from the common lines
// Assumes: commons are driven together
// Notes: an undriven line drifts, it does not keep its level
`timescale 1ns/1ns
module lcd_panel_model (
  input wire logic       pclk,       // clock
  input wire logic [3:0] com_level,  // common levels
  input wire logic [3:0] com_oe_n,   // low drives
  output logic     [3:0] seen        // commons seen selected
);
  logic [3:0] pin_q = 4'h0;
  initial seen = 4'h0;
  always @(posedge pclk)
  begin
    pin_q <= (com_level & ~com_oe_n) | (~pin_q & com_oe_n);
    if ($onehot(pin_q)) seen <= seen | pin_q;
    if ($onehot(~pin_q)) seen <= seen | ~pin_q;
  end
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the lcd driver control
// Assumes: apb answers in the access cycle
// Notes: short hold and divider keep the run brief
`timescale 1ns/1ns
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic        mcu_reset = 0, wdt_reset = 0, idle_mode = 0, sleep_mode = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, seg_data = 32'hA5C3_0F69, prdata, rd;
  logic        pl;
  logic        pready, pslverr, pump_enable, pump_boost, display_reset;
  logic [3:0]  com_level, com_oe_n, seen, c;
  logic [7:0]  segment_line, seg_oe_n;
  logic [1:0]  pump_source;
  logic [11:0] rows [7] = '{12'h010, 12'h41C, 12'h519, 12'h61A, 12'h71B, 12'h310, 12'h703};
  int          fail_count = 0, checks = 0, n;
  always #5 pclk = ~pclk;
  lcd_driver_control #(.HOLD_CYCLES(5), .DIV(2)) lcd_driver_control_inst (.*);
  lcd_panel_model lcd_panel_model_inst (.*);
  task chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    complete_run;
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    chk("dreset", {display_reset, com_oe_n}, 5'h10);
    apb(0, 12'h000, 0);
    chk("ctrl", rd, 0);
    apb(0, 12'h008, 0);
    chk("slverr", er, 1);
    // rows: control byte, then pump run, boost, source
    foreach (rows[i])
    begin
      apb(1, 12'h000, {24'h0, rows[i][11:4]});
      repeat (4) @(posedge pclk);
      chk("pump", {pump_enable, pump_boost, pump_source}, rows[i][3:0]);
    end
    chk("blank", {display_reset, com_oe_n, com_level, segment_line}, 17'h10000);
    for (int t = 0; t < 2; t++)
    begin
      apb(1, 12'h000, t ? 32'h81 : 32'h01);
      repeat (3) @(posedge pclk);
      chk("run", display_reset, 0);
      c = com_level;
      while (com_level === c) @(posedge pclk);
      c = com_level;
      n = 0;
      while (com_level === c)
      begin
        @(posedge pclk);
        n++;
      end
      chk("span", n, 2 * (t + 1));
      pl = $onehot(com_level) ? 1'b0 : 1'b1;
      c = pl ? ~com_level : com_level;
      for (int s = 0; s < 8; s++)
        chk("seg", segment_line[s], seg_data[4 * s + $clog2(c)] ^ pl);
    end
    sleep_mode <= 1;
    repeat (8) @(posedge pclk);
    chk("sleep", {display_reset, com_oe_n, com_level}, 9'h100);
    sleep_mode <= 0;
    mcu_reset <= 1;
    repeat (8) @(posedge pclk);
    chk("float", {display_reset, com_oe_n, seg_oe_n}, 13'h1FFF);
    apb(0, 12'h004, 0);
    chk("status", rd, 32'h0000_000B);
    mcu_reset <= 0;
    repeat (25) @(posedge pclk);
    chk("drive", com_oe_n, 0);
    {wdt_reset, idle_mode, mcu_reset} <= 3'b111;
    repeat (8) @(posedge pclk);
    chk("wdt", com_oe_n, 0);
    chk("seen", seen, 4'hF);
    complete_run;
  end
endmodule
